// ### charger_system_gpio_control_tb_top.sv
// Self-checking bench for the charger control register block.
// Assumes the host model drives I2C and flags each byte it reads.
`timescale 1ns/1ps
`default_nettype none
module charger_system_gpio_control_tb_top
  import cspgc_pkg::*;
;
  logic        clk_sys = 1'b0, rst_b = 1'b0;
  logic        scl_i, sda_i, sda_o, sda_oe_n, rd_vld, iok, cil, ntc_hot, clamp_trip, conv_en, irq_n;
  logic [7:0]  rd_byte, r;
  logic [7:1]  evt_lo;
  logic [4:1]  evt_hi;
  logic [3:0]  pad_i, pad_o, pad_oe_n, pad_ext;
  cspgc_rect_t rect_mode;
  logic [7:0]  exp_q[$];
  int          fail_count = 0, n_compared = 0;
  always #4 clk_sys = ~clk_sys;
  // Pins have pull-ups; a board source may pull them too
  assign pad_i = pad_ext & (pad_oe_n | pad_o);
  cspgc_host_model cspgc_host_model_inst (.clk_sys(clk_sys), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .scl_i(scl_i), .sda_i(sda_i), .rd_vld(rd_vld), .rd_byte(rd_byte));
  cspgc_ctrl cspgc_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .evt_lo(evt_lo), .evt_hi(evt_hi), .input_ok_level(iok),
    .charger_input_level(cil), .ntc_hot(ntc_hot), .clamp_trip(clamp_trip), .converter_enable(conv_en),
    .rect_mode(rect_mode), .irq_n(irq_n), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_n(pad_oe_n));
  task automatic cmp(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, want);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    cspgc_host_model_inst.wr(p, d);
  endtask
  // Notes up to three expected bytes, first one in the top bits
  task automatic rdq(input logic [7:0] p, input logic [23:0] e, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(e[23-8*i -: 8]);
    cspgc_host_model_inst.rd(p, n);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    if (rd_vld === 1'b1 && exp_q.size() == 0) cmp(8'h00, 8'h01);
    else if (rd_vld === 1'b1) cmp(rd_byte, exp_q.pop_front());
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'hd98668c6));
    {evt_lo, evt_hi, cil, ntc_hot, clamp_trip} = '0;
    iok = 1'b1;
    pad_ext = 4'hF;
    repeat (6) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    settle();
    cmp({conv_en, irq_n, rect_mode, pad_oe_n}, 8'hCF);
    rdq(8'h05, 24'h80F50F, 3);
    for (int m = 0; m < 4; m++) begin
      wr(8'h05, 8'h80 | 8'(m << 4));
      cmp({6'h00, rect_mode}, (m == 3) ? 8'h00 : 8'(m));
      rdq(8'h05, {(m == 3) ? 8'h80 : 8'h80 | 8'(m << 4), 16'h0000}, 1);
    end
    for (int k = 0; k < 3; k++) begin
      r = 8'($urandom);
      pad_ext = 4'($urandom);
      wr(8'h07, r);
      cmp({4'h0, pad_oe_n}, {4'h0, r[3:0]});
      rdq(8'h07, {r, 4'h0, r[7:4] & r[3:0] & pad_ext, 8'h00}, 2);
    end
    pad_ext = 4'hF;
    wr(8'h07, 8'h0F);
    wr(8'h05, 8'h84);
    ntc_hot = 1'b1;
    settle();
    cmp({4'h0, pad_oe_n}, 8'h0C);
    wr(8'h05, 8'h80);
    cmp({4'h0, pad_oe_n}, 8'h0F);
    ntc_hot = 1'b0;
    wr(8'h04, 8'h47);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h01);
    evt_lo[1] = 1'b1;
    settle();
    cmp({conv_en, irq_n}, 8'h02);
    rdq(8'h00, 24'h030300, 2);
    wr(8'h05, 8'h80);
    rdq(8'h00, 24'h030100, 2);
    cmp({7'h00, irq_n}, 8'h01);
    evt_lo[1] = 1'b0;
    for (int k = 0; k < 3; k++) begin
      wr(8'h06, 8'h05);
      wr(8'h05, 8'h80 | ((k == 0) ? 8'h01 : (k == 1) ? 8'h08 : 8'h40));
      {ntc_hot, clamp_trip} = 2'b11;
      {evt_hi[4], evt_lo[5], evt_lo[1]} = 3'b001 << k;
      settle();
      cmp({7'h00, conv_en}, 8'h00);
      {evt_hi[4], evt_lo[5], evt_lo[1], ntc_hot, clamp_trip} = '0;
      wr(8'h02, 8'hFE);
      wr(8'h03, 8'h1B);
    end
    wr(8'h04, 8'h80);
    cil = 1'b1;
    settle();
    cmp({7'h00, irq_n}, 8'h00);
    rdq(8'h01, 24'h010000, 1);
    cmp({7'h00, irq_n}, 8'h01);
    cspgc_host_model_inst.hp = 7;
    wr(8'h07, 8'h30);
    wr(8'h06, 8'h07);
    rdq(8'h05, 24'h80F50F, 3);
    cspgc_host_model_inst.start();
    cspgc_host_model_inst.xfer({7'h15, 1'b0, 1'b1});
    cmp({7'h00, cspgc_host_model_inst.rx[0]}, 8'h01);
    cspgc_host_model_inst.stop();
    settle();
    cmp(8'(exp_q.size()), 8'h00);
    summarize();
  end
endmodule
`default_nettype wire

// ### cspgc_ctrl.sv
// Control register bank of the receiver front end behind an I2C slave.
// Assumes SCL and SDA are already synchronous to clk_sys and sampled often enough.
`timescale 1ns/1ps
`include "cspgc_params.svh"
`default_nettype none
module cspgc_ctrl
  import cspgc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `CSPGC_DEV_ADDR,
  parameter int         N_PINS   = 4
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // I2C pins
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  // Event and level sources
  input  wire logic [7:1]        evt_lo,
  input  wire logic [4:1]        evt_hi,
  input  wire logic              input_ok_level,
  input  wire logic              charger_input_level,
  input  wire logic              ntc_hot,
  input  wire logic              clamp_trip,
  // Converter and rectifier control, and interrupt output
  output logic                   converter_enable,
  output cspgc_rect_t            rect_mode,
  output logic                   irq_n,
  // General-purpose pins
  input  wire logic [N_PINS-1:0] pad_i,
  output logic      [N_PINS-1:0] pad_o,
  output logic      [N_PINS-1:0] pad_oe_n
);
  cspgc_state_t state_q;
  cspgc_state_t nxt_q;
  logic         scl_q;
  logic         sda_q;
  logic [7:0]   shreg_q;
  logic [3:0]   cnt_q;
  logic         mack_q;
  logic [7:0]   ptr_q;
  logic         wr_stb_q;
  logic [7:0]   wr_addr_q;
  logic [7:0]   wr_data_q;
  logic [7:0]   sys_lo_q;
  logic [7:0]   sys_hi_q;
  logic [7:0]   pin_ctl_q;
  logic [7:0]   irq_en_q;
  logic         soft_reset_pend_q;
  logic         soft_rst_q;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_c;
  logic         stop_c;
  logic         byte_done;
  logic         rd_load;
  logic         ptr_step;
  logic [7:0]   rd_data;
  logic [7:0]   status_low;
  logic [7:0]   status_high;
  logic [N_PINS-1:0] pin_level;
  logic         cut;
  logic         protect_low;
  logic         auto_inc;

  // Bus conditions
  assign scl_rise  = scl_i && !scl_q;
  assign scl_fall  = !scl_i && scl_q;
  assign start_c   = scl_i && scl_q && sda_q && !sda_i;
  assign stop_c    = scl_i && scl_q && !sda_q && sda_i;
  assign byte_done = scl_fall && cnt_q == `CSPGC_BYTE_BITS;
  assign rd_load   = scl_fall && ((state_q == CSPGC_ACK && nxt_q == CSPGC_RD) ||
                                  (state_q == CSPGC_MACK && mack_q));
  assign ptr_step  = rd_load || (state_q == CSPGC_WR && byte_done);
  assign auto_inc  = sys_hi_q[`CSPGC_SH_AUTO_INC];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Byte engine; a start anywhere restarts address phase
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= CSPGC_IDLE;
      nxt_q   <= CSPGC_IDLE;
      shreg_q <= 8'h00;
      cnt_q   <= 4'h0;
      mack_q  <= 1'b0;
    end else if (start_c) begin
      state_q <= CSPGC_DEV;
      cnt_q   <= 4'h0;
    end else if (stop_c) begin
      state_q <= CSPGC_IDLE;
    end else begin
      case (state_q)
        CSPGC_DEV, CSPGC_PTR, CSPGC_WR: begin
          if (scl_rise) begin
            shreg_q <= {shreg_q[6:0], sda_i};
            cnt_q   <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            if (state_q != CSPGC_DEV) begin
              state_q <= CSPGC_ACK;
              nxt_q   <= CSPGC_WR;
            end else if (shreg_q[7:1] == DEV_ADDR) begin
              state_q <= CSPGC_ACK;
              nxt_q   <= shreg_q[0] ? CSPGC_RD : CSPGC_PTR;
            end else begin
              state_q <= CSPGC_IDLE;
            end
          end
        end
        CSPGC_ACK: begin
          if (scl_fall) begin
            state_q <= nxt_q;
            cnt_q   <= 4'h0;
            if (nxt_q == CSPGC_RD) begin
              shreg_q <= rd_data;
            end
          end
        end
        CSPGC_RD: begin
          if (scl_fall) begin
            shreg_q <= {shreg_q[6:0], 1'b0};
            cnt_q   <= cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              state_q <= CSPGC_MACK;
              cnt_q   <= 4'h0;
            end
          end
        end
        CSPGC_MACK: begin
          if (scl_rise) begin
            mack_q <= !sda_i;
          end else if (scl_fall) begin
            state_q <= mack_q ? CSPGC_RD : CSPGC_IDLE;
            if (mack_q) begin
              shreg_q <= rd_data;
            end
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Open-drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_n = !(state_q == CSPGC_ACK || (state_q == CSPGC_RD && !shreg_q[7]));

  // Write strobe carries the address in force before the pointer steps
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_stb_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q  <= state_q == CSPGC_WR && byte_done;
      wr_addr_q <= ptr_q;
      wr_data_q <= shreg_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst_q) begin
      ptr_q <= 8'h00;
    end else if (state_q == CSPGC_PTR && byte_done) begin
      ptr_q <= shreg_q;
    end else if (ptr_step && auto_inc) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Soft reset waits for the stop so the current transfer ends cleanly
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      soft_reset_pend_q <= 1'b0;
      soft_rst_q  <= 1'b0;
    end else begin
      soft_rst_q <= soft_reset_pend_q && stop_c;
      if (soft_rst_q) begin
        soft_reset_pend_q <= 1'b0;
      end else if (wr_stb_q && wr_addr_q == `CSPGC_OFF_SYS_HI && wr_data_q[`CSPGC_SH_SOFT_RST]) begin
        soft_reset_pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst_q) begin
      sys_lo_q <= `CSPGC_RST_SYS_LO;
    end else if (wr_stb_q && wr_addr_q == `CSPGC_OFF_SYS_LO) begin
      sys_lo_q <= wr_data_q & `CSPGC_SYS_LO_WMASK;
      if (wr_data_q[`CSPGC_SL_PASSIVE] && wr_data_q[`CSPGC_SL_HALF]) begin
        sys_lo_q[`CSPGC_SL_PASSIVE] <= 1'b0;
        sys_lo_q[`CSPGC_SL_HALF]    <= 1'b0;
      end
    end
  end

  // Protective cut beats a software write of the enable in the same cycle
  assign cut = (sys_lo_q[`CSPGC_SL_OT_CUT] &&
                ((status_low[`CSPGC_ST_OT1] && irq_en_q[`CSPGC_IE_OT1]) ||
                 (status_low[`CSPGC_ST_OT2] && irq_en_q[`CSPGC_IE_OT2]))) ||
               (sys_lo_q[`CSPGC_SL_NTC_CUT] && ntc_hot &&
                status_low[`CSPGC_ST_NTC_HI] && irq_en_q[`CSPGC_IE_NTC_HI]) ||
               (sys_lo_q[`CSPGC_SL_OV_CUT] && clamp_trip &&
                status_high[`CSPGC_STH_OVP] && irq_en_q[`CSPGC_IE_OVP]);

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst_q) begin
      sys_hi_q <= `CSPGC_RST_SYS_HI;
    end else begin
      if (wr_stb_q && wr_addr_q == `CSPGC_OFF_SYS_HI) begin
        sys_hi_q <= {wr_data_q[7:2], 1'b0, wr_data_q[0]};
      end
      if (cut) begin
        sys_hi_q[`CSPGC_SH_CONV_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst_q) begin
      pin_ctl_q <= `CSPGC_RST_PIN_CTL;
      irq_en_q  <= `CSPGC_RST_IRQ_EN;
    end else if (wr_stb_q) begin
      if (wr_addr_q == `CSPGC_OFF_PIN_CTL) begin
        pin_ctl_q <= wr_data_q;
      end
      if (wr_addr_q == `CSPGC_OFF_IRQ_EN) begin
        irq_en_q <= wr_data_q;
      end
    end
  end

  always_comb begin
    case (ptr_q)
      `CSPGC_OFF_STAT_LO:  rd_data = status_low;
      `CSPGC_OFF_STAT_HI:  rd_data = status_high;
      `CSPGC_OFF_IRQ_EN:   rd_data = irq_en_q;
      `CSPGC_OFF_SYS_LO:   rd_data = sys_lo_q;
      `CSPGC_OFF_SYS_HI:   rd_data = sys_hi_q;
      `CSPGC_OFF_PIN_CTL:  rd_data = pin_ctl_q;
      `CSPGC_OFF_PIN_IN:   rd_data = {4'h0, pin_level[3:0]};
      default:             rd_data = 8'h00;
    endcase
  end

  assign converter_enable = sys_hi_q[`CSPGC_SH_CONV_EN];
  assign rect_mode        = cspgc_rect_t'({sys_lo_q[`CSPGC_SL_HALF], sys_lo_q[`CSPGC_SL_PASSIVE]});
  assign protect_low      = sys_lo_q[`CSPGC_SL_NTC_PROT] && ntc_hot;

  cspgc_status_flags u_flags (
    .clk_sys             (clk_sys),
    .rst_b               (rst_b),
    .soft_rst            (soft_rst_q),
    .evt_lo              (evt_lo),
    .evt_hi              (evt_hi),
    .input_ok_level      (input_ok_level),
    .charger_input_level (charger_input_level),
    .irq_en              (irq_en_q),
    .clr_wr_lo           (wr_stb_q && wr_addr_q == `CSPGC_OFF_CLR_LO),
    .clr_wr_hi           (wr_stb_q && wr_addr_q == `CSPGC_OFF_CLR_HI),
    .wr_data             (wr_data_q),
    .rd_stb              (rd_load),
    .rd_addr             (ptr_q),
    .auto_clear_on_read  (sys_lo_q[`CSPGC_SL_AUTO_CLR]),
    .status_low          (status_low),
    .status_high         (status_high),
    .irq_n               (irq_n)
  );

  cspgc_pin_ctl #(
    .N_PINS (N_PINS),
    .N_PROT (2)
  ) u_pins (
    .clk_sys             (clk_sys),
    .rst_b               (rst_b),
    .pin_drive_bit       (pin_ctl_q[N_PINS-1:0]),
    .pin_input_buffer_en (pin_ctl_q[N_PINS+3:4]),
    .protect_low         (protect_low),
    .pad_i               (pad_i),
    .pad_o               (pad_o),
    .pad_oe_n            (pad_oe_n),
    .pin_input_level     (pin_level)
  );

  property p_ot_cut;
    @(posedge clk_sys) disable iff (!rst_b)
      sys_lo_q[0] && status_low[1] && irq_en_q[0] && !soft_rst_q |=> !converter_enable;
  endproperty
  a_ot_cut: assert property (p_ot_cut) else $error("over-temperature cut missed");

  property p_no_cut;
    @(posedge clk_sys) disable iff (!rst_b)
      !cut && !soft_rst_q && !(wr_stb_q && wr_addr_q == 8'h06) |=> $stable(converter_enable);
  endproperty
  a_no_cut: assert property (p_no_cut) else $error("converter changed without cause");

  property p_ntc_cut;
    @(posedge clk_sys) disable iff (!rst_b)
      sys_lo_q[3] && ntc_hot && status_low[5] && irq_en_q[2] && !soft_rst_q |=> !converter_enable;
  endproperty
  a_ntc_cut: assert property (p_ntc_cut) else $error("thermistor cut missed");

  property p_ov_cut;
    @(posedge clk_sys) disable iff (!rst_b)
      sys_lo_q[6] && clamp_trip && status_high[4] && irq_en_q[6] && !soft_rst_q |=> !converter_enable;
  endproperty
  a_ov_cut: assert property (p_ov_cut) else $error("over-voltage cut missed");

  property p_rect_excl;
    @(posedge clk_sys) disable iff (!rst_b)
      wr_stb_q && wr_addr_q == 8'h05 && wr_data_q[5:4] == 2'b11 |=> rect_mode == CSPGC_ACTIVE;
  endproperty
  a_rect_excl: assert property (p_rect_excl) else $error("both rectifier bits kept");

  property p_soft_rst;
    @(posedge clk_sys) disable iff (!rst_b)
      soft_reset_pend_q && stop_c |=> ##1 sys_lo_q == 8'h80 && sys_hi_q == 8'hF5 && pin_ctl_q == 8'h0F;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset did not restore");

  property p_ptr_step;
    @(posedge clk_sys) disable iff (!rst_b)
      ptr_step && !soft_rst_q && !(state_q == CSPGC_PTR) |=>
        ptr_q == ($past(auto_inc) ? $past(ptr_q) + 8'h01 : $past(ptr_q));
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong");
endmodule
`default_nettype wire

// ### cspgc_host_model.sv
// Behavioural I2C bus master standing in for the host controller.
// Assumes an open-drain SDA wire with a pull-up; SCL is driven by this model only.
`timescale 1ns/1ps
`include "cspgc_params.svh"
`default_nettype none
module cspgc_host_model (
  // Bus
  input  wire logic       clk_sys,
  input  wire logic       sda_o,
  input  wire logic       sda_oe_n,
  output logic            scl_i,
  output logic            sda_i,
  // Read results
  output logic            rd_vld,
  output logic [7:0]      rd_byte
);
  logic       sda_m = 1'b1;
  logic [8:0] rx;
  // Cycles per third of a bit; the bench raises it for slow traffic
  int         hp    = 3;
  // Wired AND of both parties with the pull-up
  assign sda_i = sda_m & (sda_oe_n | sda_o);
  initial begin
    scl_i   = 1'b1;
    rd_vld  = 1'b0;
    rd_byte = 8'h00;
  end
  task automatic tick();
    repeat (hp) @(posedge clk_sys);
    #1;
  endtask
  // Also serves as repeated start from a low SCL
  task automatic start();
    sda_m = 1'b1;
    tick();
    scl_i = 1'b1;
    tick();
    sda_m = 1'b0;
    tick();
    scl_i = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_m = 1'b0;
    tick();
    scl_i = 1'b1;
    tick();
    sda_m = 1'b1;
    tick();
  endtask
  // Eight data bits then the acknowledge slot
  task automatic xfer(input logic [8:0] tx);
    for (int i = 8; i >= 0; i--) begin
      sda_m = tx[i];
      tick();
      scl_i = 1'b1;
      tick();
      rx[i] = sda_i;
      scl_i = 1'b0;
      tick();
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
    start();
    xfer({`CSPGC_DEV_ADDR, 1'b0, 1'b1});
    xfer({ptr, 1'b1});
    xfer({dat, 1'b1});
    stop();
  endtask
  // All bytes in one transaction so no auto-cleared event is lost
  task automatic rd(input logic [7:0] ptr, input int n);
    start();
    xfer({`CSPGC_DEV_ADDR, 1'b0, 1'b1});
    xfer({ptr, 1'b1});
    start();
    xfer({`CSPGC_DEV_ADDR, 1'b1, 1'b1});
    for (int i = 1; i <= n; i++) begin
      xfer({8'hFF, i == n});
      rd_byte = rx[8:1];
      rd_vld  = 1'b1;
      @(posedge clk_sys);
      #1;
      rd_vld  = 1'b0;
    end
    stop();
  endtask
endmodule
`default_nettype wire

// ### cspgc_params.svh
// Register map, reset values and field positions of the charger control block.
// Included by the control, status-flag and host-model modules; the package and pin module do not include it.
// Overview of operation
// - Auto-clear set: reading a status register clears its event flags and interrupt.
// - Auto-clear off: flags stay set until a 1 is written to the clear register.
// - Over-temperature cut bit: enabled junction flag clears the converter enable.
// - NTC protect bit: pins one and two pulled low while the thermistor limit is exceeded.
// - NTC cut bit: enabled thermistor flag at limit clears the converter enable.
// - Bits 4 and 5 pick passive, half-active or, both clear, active rectification.
// - Both rectifier bits written as one are forced back to 00b.
// - Over-voltage cut bit: enabled flag at clamp trip clears the converter enable.
// - Upper bit 0 enables the step-down converter; reset value 1.
// - Soft reset bit restores all registers at the next stop; it reads as 0.
// - Auto-increment bit, default 1, steps the pointer after each data byte.
// - Upper bits 7:4 reset to 1, bit 3 to 0; software writes them as 0.
// - Output bit 1 leaves the open-drain pin floating, 0 pulls it low.
// - Pins one and two pulled low by control bit 0 OR protection request.
// - Bits 4 to 7 enable input buffers; levels show only while enabled.
// - Auto-clear never touches the live input-ok and charger-input levels.
`ifndef CSPGC_PARAMS_SVH
`define CSPGC_PARAMS_SVH
`define CSPGC_OFF_STAT_LO   8'h00
`define CSPGC_OFF_STAT_HI   8'h01
`define CSPGC_OFF_CLR_LO    8'h02
`define CSPGC_OFF_CLR_HI    8'h03
`define CSPGC_OFF_IRQ_EN    8'h04
`define CSPGC_OFF_SYS_LO    8'h05
`define CSPGC_OFF_SYS_HI    8'h06
`define CSPGC_OFF_PIN_CTL   8'h07
`define CSPGC_OFF_PIN_IN    8'h08
`define CSPGC_RST_SYS_LO    8'h80
`define CSPGC_RST_SYS_HI    8'hF5
`define CSPGC_RST_PIN_CTL   8'h0F
`define CSPGC_RST_IRQ_EN    8'h00
`define CSPGC_SYS_LO_WMASK  8'hFD
`define CSPGC_HI_FLAG_MASK  4'hD
`define CSPGC_DEV_ADDR      7'h2A
`define CSPGC_BYTE_BITS     4'h8
`define CSPGC_SL_OT_CUT     0
`define CSPGC_SL_NTC_PROT   2
`define CSPGC_SL_NTC_CUT    3
`define CSPGC_SL_PASSIVE    4
`define CSPGC_SL_HALF       5
`define CSPGC_SL_OV_CUT     6
`define CSPGC_SL_AUTO_CLR   7
`define CSPGC_SH_CONV_EN    0
`define CSPGC_SH_SOFT_RST   1
`define CSPGC_SH_AUTO_INC   2
`define CSPGC_ST_OT1        1
`define CSPGC_ST_OT2        2
`define CSPGC_ST_NTC_HI     5
`define CSPGC_STH_OVP       4
`define CSPGC_IE_OT1        0
`define CSPGC_IE_OT2        1
`define CSPGC_IE_NTC_HI     2
`define CSPGC_IE_OVP        6
`endif

// ### cspgc_pin_ctl.sv
// Open-drain general-purpose pins with protection override and input buffers.
// Assumes pad inputs are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module cspgc_pin_ctl
  import cspgc_pkg::*;
#(
  parameter int N_PINS = 4,
  parameter int N_PROT = 2
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Control
  input  wire logic [N_PINS-1:0] pin_drive_bit,
  input  wire logic [N_PINS-1:0] pin_input_buffer_en,
  input  wire logic              protect_low,
  // Pads
  input  wire logic [N_PINS-1:0] pad_i,
  output logic      [N_PINS-1:0] pad_o,
  output logic      [N_PINS-1:0] pad_oe_n,
  output logic      [N_PINS-1:0] pin_input_level
);
  assign pad_o = '0;

  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    logic pull;
    logic oe_n_q;
    logic lvl_q;
    // Protection can only pull low, never release a pin held by software
    assign pull = !pin_drive_bit[i] || (i < N_PROT && protect_low);
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        oe_n_q <= 1'b1;
        lvl_q  <= 1'b0;
      end else begin
        oe_n_q <= !pull;
        lvl_q  <= pin_input_buffer_en[i] && pad_i[i];
      end
    end
    assign pad_oe_n[i]        = oe_n_q;
    assign pin_input_level[i] = lvl_q;

    property p_pull;
      @(posedge clk_sys) disable iff (!rst_b)
        (!pin_drive_bit[i] || (i < N_PROT && protect_low)) |=> !pad_oe_n[i];
    endproperty
    a_pull: assert property (p_pull) else $error("pin not pulled low");
  end
endmodule
`default_nettype wire

// ### cspgc_pkg.sv
// Types shared by the charger control modules.
// Assumes the constants header sits in the same folder.
`default_nettype none
package cspgc_pkg;
  typedef enum logic [2:0] {
    CSPGC_IDLE = 3'b000,
    CSPGC_DEV  = 3'b001,
    CSPGC_PTR  = 3'b010,
    CSPGC_WR   = 3'b011,
    CSPGC_ACK  = 3'b100,
    CSPGC_RD   = 3'b101,
    CSPGC_MACK = 3'b110
  } cspgc_state_t;
  typedef enum logic [1:0] {
    CSPGC_ACTIVE  = 2'b00,
    CSPGC_PASSIVE = 2'b01,
    CSPGC_HALFACT = 2'b10
  } cspgc_rect_t;
endpackage
`default_nettype wire

// ### cspgc_status_flags.sv
// Event flags, hidden charger-input latch and interrupt output.
// Assumes event inputs are synchronous levels; strobes last one cycle.
`timescale 1ns/1ps
`include "cspgc_params.svh"
`default_nettype none
module cspgc_status_flags
  import cspgc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       soft_rst,
  // Event and level sources
  input  wire logic [7:1] evt_lo,
  input  wire logic [4:1] evt_hi,
  input  wire logic       input_ok_level,
  input  wire logic       charger_input_level,
  // Register side
  input  wire logic [7:0] irq_en,
  input  wire logic       clr_wr_lo,
  input  wire logic       clr_wr_hi,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_stb,
  input  wire logic [7:0] rd_addr,
  input  wire logic       auto_clear_on_read,
  output logic      [7:0] status_low,
  output logic      [7:0] status_high,
  output logic            irq_n
);
  logic [7:1] lo_q;
  logic [4:1] hi_q;
  logic [7:1] evt_lo_q;
  logic [4:1] evt_hi_q;
  logic       ta_q;
  logic       ta_lat_q;
  logic       irq_n_q;
  logic       rd_lo;
  logic       rd_hi;
  logic [7:1] clr_lo;
  logic [4:1] clr_hi;
  logic [7:1] mask_lo;
  logic [4:1] mask_hi;

  assign rd_lo   = rd_stb && auto_clear_on_read && rd_addr == `CSPGC_OFF_STAT_LO;
  assign rd_hi   = rd_stb && auto_clear_on_read && rd_addr == `CSPGC_OFF_STAT_HI;
  assign clr_lo  = (clr_wr_lo ? wr_data[7:1] : 7'h00) | {7{rd_lo}};
  assign clr_hi  = (clr_wr_hi ? wr_data[4:1] : 4'h0) | {4{rd_hi}};
  assign mask_lo = {irq_en[4], irq_en[3], irq_en[2], irq_en[1], irq_en[0], irq_en[1], irq_en[0]};
  assign mask_hi = {irq_en[6], irq_en[5], 1'b0, 1'b0};

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst) begin
      evt_lo_q <= 7'h00;
      evt_hi_q <= 4'h0;
      ta_q     <= 1'b0;
    end else begin
      evt_lo_q <= evt_lo;
      evt_hi_q <= evt_hi;
      ta_q     <= charger_input_level;
    end
  end

  // New edges win over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst) begin
      lo_q     <= 7'h00;
      hi_q     <= 4'h0;
      ta_lat_q <= 1'b0;
    end else begin
      lo_q     <= (evt_lo & ~evt_lo_q) | (lo_q & ~clr_lo);
      hi_q     <= ((evt_hi & ~evt_hi_q) | (hi_q & ~clr_hi)) & `CSPGC_HI_FLAG_MASK;
      ta_lat_q <= (charger_input_level ^ ta_q) | (ta_lat_q & ~(rd_hi | (clr_wr_hi & wr_data[0])));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_rst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~(|(lo_q & mask_lo) | |(hi_q & mask_hi) | (ta_lat_q & irq_en[7]));
    end
  end

  // Live levels bypass the latches entirely
  assign status_low  = {lo_q, input_ok_level};
  assign status_high = {3'b000, hi_q, charger_input_level};
  assign irq_n       = irq_n_q;

  property p_auto_clear;
    @(posedge clk_sys) disable iff (!rst_b || soft_rst)
      rd_lo && !soft_rst |=> lo_q == ($past(evt_lo) & ~$past(evt_lo_q));
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("flags not cleared by read");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_b || soft_rst)
      !auto_clear_on_read && !clr_wr_lo && lo_q[1] |=> lo_q[1];
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost without clear");
endmodule
`default_nettype wire
